// [src/ifeb_pkg.sv]
package ifeb_pkg;

    localparam int unsigned addr_w = 12;
    localparam int unsigned data_w = 32;
    localparam int unsigned reg_w = 16;
    localparam int unsigned prio_w = 3;
    localparam int unsigned num_groups = 4;
    localparam int unsigned strb_w = data_w / 8;

    // Register byte addresses.
    localparam logic [11:0] flag_status_four_off = 12'h000;
    localparam logic [11:0] source_enable_zero_off = 12'h004;
    localparam logic [11:0] source_enable_one_off = 12'h008;
    localparam logic [11:0] source_enable_two_off = 12'h00c;
    localparam logic [11:0] group_priority_off = 12'h010;
    localparam logic [11:0] event_status_off = 12'h014;
    localparam logic [11:0] event_clear_off = 12'h018;
    localparam logic [11:0] event_enable_off = 12'h01c;

    // Bit positions of the fourth flag register.
    localparam int unsigned can2_tx_request_flag = 7;
    localparam int unsigned can1_tx_request_flag = 6;
    localparam int unsigned dma_ch7_done_flag = 5;
    localparam int unsigned dma_ch6_done_flag = 4;
    localparam int unsigned uart2_error_flag = 2;
    localparam int unsigned uart1_error_flag = 1;

    // Implemented bit masks; every other position reads zero and ignores writes.
    localparam logic [15:0] flag_status_four_mask =
        (16'h0001 << can2_tx_request_flag) | (16'h0001 << can1_tx_request_flag) |
        (16'h0001 << dma_ch7_done_flag) | (16'h0001 << dma_ch6_done_flag) |
        (16'h0001 << uart2_error_flag) | (16'h0001 << uart1_error_flag);
    localparam logic [15:0] source_enable_zero_mask = 16'h7fff;
    localparam logic [15:0] source_enable_one_mask = 16'hfffb;
    localparam logic [15:0] source_enable_two_mask = 16'hdfff;

    // Reset values.
    localparam logic [15:0] flag_reset = 16'h0000;
    localparam logic [15:0] enable_reset = 16'h0000;
    // Four in every packed 3-bit group field; all twelve bits are field bits.
    localparam logic [11:0] group_priority_reset = 12'h924;
    localparam logic [11:0] group_priority_mask = 12'hfff;
    localparam logic [3:0] event_reset = 4'h0;

    // Priority encoding: zero disables the source, seven is highest.
    localparam logic [2:0] prio_disabled = 3'h0;

    // Group order in priority fields and event bits.
    localparam int unsigned grp_four = 0;
    localparam int unsigned grp_zero = 1;
    localparam int unsigned grp_one = 2;
    localparam int unsigned grp_two = 3;

    typedef enum logic [1:0] {
        apb_idle = 2'b01,
        apb_ack = 2'b10
    } ifeb_apb_state_t;

endpackage

// [src/ifeb_flag_reg.sv]
`timescale 1ns/10ps
module ifeb_flag_reg #(
    parameter int unsigned WIDTH = 16,
    parameter logic [WIDTH-1:0] IMPL_MASK = '1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [WIDTH-1:0] set_pulse,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] q_nxt;

    if ((RESET_VAL & ~IMPL_MASK) != '0) begin : g_bad_reset
        $error("Reset value sets an unimplemented bit.");
    end

    // A request in the same cycle as a software write of zero still leaves the bit set.
    always_comb begin
        q_nxt = ((wr_en ? wr_data : q) | set_pulse) & IMPL_MASK;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_VAL & IMPL_MASK;
        end else begin
            q <= q_nxt;
        end
    end

endmodule // ifeb_flag_reg

// [src/ifeb_prio_sel.sv]
`timescale 1ns/10ps
module ifeb_prio_sel #(
    parameter int unsigned N = 4
) (
    input wire logic [N-1:0] pending,
    input wire logic [N*3-1:0] levels,
    output logic [2:0] level
);

    if (N == 0) begin : g_bad_n
        $error("At least one group is needed.");
    end

    // Groups at level zero never win, so a disabled group cannot raise the level.
    function automatic logic [2:0] max_level(input logic [N-1:0] p,
                                             input logic [N*3-1:0] l);
        logic [2:0] m;
        m = ifeb_pkg::prio_disabled;
        for (int i = 0; i < N; i++) begin
            if (p[i] && l[i*3 +: 3] > m) begin
                m = l[i*3 +: 3];
            end
        end
        return m;
    endfunction

    always_comb begin
        level = max_level(pending, levels);
    end

endmodule // ifeb_prio_sel

// [src/ifeb_top.sv]
// Overview of operation
// - Flag reads one after request, else zero.
// - Enable one passes request, zero blocks it.
// - Unimplemented bits read zero, ignore writes.
// - Reset clears all flags and enables.
// - Flags and enables are software read/write.
// - Fourth flag register bit layout.
// - Enable zero upper byte layout.
// - Enable zero lower byte layout.
// - Enable one upper byte layout.
// - Enable one lower byte layout.
// - Enable two upper byte layout.
// - Enable two lower byte layout.
// - Priority zero disables, one to seven ranks.
`timescale 1ns/10ps
module ifeb_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] flag_set_four,
    input wire logic [15:0] enable_in_four,
    input wire logic [15:0] flag_in_zero,
    input wire logic [15:0] flag_in_one,
    input wire logic [15:0] flag_in_two,
    output logic [15:0] flag_out_four,
    output logic [15:0] req_four,
    output logic [15:0] req_zero,
    output logic [15:0] req_one,
    output logic [15:0] req_two,
    output logic [2:0] irq_level,
    output logic irq
);

    ifeb_pkg::ifeb_apb_state_t state_r;
    ifeb_pkg::ifeb_apb_state_t state_nxt;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic addr_ok;
    logic wr_fire;
    logic [15:0] flag_four_q;
    logic [15:0] en_zero_q;
    logic [15:0] en_one_q;
    logic [15:0] en_two_q;
    logic [15:0] wr_half;
    logic wr_four;
    logic wr_zero;
    logic wr_one;
    logic wr_two;
    logic [11:0] prio_r;
    logic [15:0] prio_wr;
    logic [3:0] ev_status_r;
    logic [3:0] ev_status_nxt;
    logic [3:0] ev_enable_r;
    logic [3:0] ev_set;
    logic [3:0] ev_clear;
    logic [3:0] grp_any_r;
    logic [3:0] grp_any_nxt;
    logic [15:0] req_four_r;
    logic [15:0] req_zero_r;
    logic [15:0] req_one_r;
    logic [15:0] req_two_r;
    logic [2:0] level_nxt;
    logic [2:0] irq_level_r;
    logic irq_r;

    // Writes merge per byte lane so a partial store leaves the other lane intact.
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] st);
        logic [15:0] r;
        r = old_v;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    function automatic logic [2:0] grp_prio(input logic [11:0] p, input int unsigned g);
        return p[g*3 +: 3];
    endfunction

    function automatic logic [15:0] gate(input logic [15:0] flags,
                                         input logic [15:0] enables,
                                         input logic [2:0] prio);
        return (prio == ifeb_pkg::prio_disabled) ? 16'h0000 : (flags & enables);
    endfunction

    // Bus slave: setup cycle decodes, access cycle completes with no wait state.
    always_comb begin
        addr_ok = hit(paddr, ifeb_pkg::flag_status_four_off) ||
                  hit(paddr, ifeb_pkg::source_enable_zero_off) ||
                  hit(paddr, ifeb_pkg::source_enable_one_off) ||
                  hit(paddr, ifeb_pkg::source_enable_two_off) ||
                  hit(paddr, ifeb_pkg::group_priority_off) ||
                  hit(paddr, ifeb_pkg::event_status_off) ||
                  hit(paddr, ifeb_pkg::event_clear_off) ||
                  hit(paddr, ifeb_pkg::event_enable_off);
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ifeb_pkg::apb_idle: begin
                if (psel && !penable) begin
                    state_nxt = ifeb_pkg::apb_ack;
                end
            end
            ifeb_pkg::apb_ack: begin
                state_nxt = ifeb_pkg::apb_idle;
            end
            default: begin
                state_nxt = ifeb_pkg::apb_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ifeb_pkg::apb_idle;
            pready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pready_r <= (state_nxt == ifeb_pkg::apb_ack);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_r <= !addr_ok;
        end else if (pready_r) begin
            pslverr_r <= 1'b0;
        end
    end

    assign wr_fire = psel && penable && pready_r && pwrite && !pslverr_r;

    // Unimplemented bits come out of the masked registers as zero.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit(paddr, ifeb_pkg::flag_status_four_off)) begin
            rdata_nxt[15:0] = flag_four_q;
        end else if (hit(paddr, ifeb_pkg::source_enable_zero_off)) begin
            rdata_nxt[15:0] = en_zero_q;
        end else if (hit(paddr, ifeb_pkg::source_enable_one_off)) begin
            rdata_nxt[15:0] = en_one_q;
        end else if (hit(paddr, ifeb_pkg::source_enable_two_off)) begin
            rdata_nxt[15:0] = en_two_q;
        end else if (hit(paddr, ifeb_pkg::group_priority_off)) begin
            rdata_nxt[11:0] = prio_r;
        end else if (hit(paddr, ifeb_pkg::event_status_off)) begin
            rdata_nxt[3:0] = ev_status_r;
        end else if (hit(paddr, ifeb_pkg::event_enable_off)) begin
            rdata_nxt[3:0] = ev_enable_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rdata_nxt;
        end else if (pready_r) begin
            prdata_r <= 32'h0000_0000;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Register bank writes.
    always_comb begin
        wr_four = wr_fire && hit(paddr, ifeb_pkg::flag_status_four_off);
        wr_zero = wr_fire && hit(paddr, ifeb_pkg::source_enable_zero_off);
        wr_one = wr_fire && hit(paddr, ifeb_pkg::source_enable_one_off);
        wr_two = wr_fire && hit(paddr, ifeb_pkg::source_enable_two_off);
        wr_half = 16'h0000;
        if (wr_four) begin
            wr_half = merge16(flag_four_q, pwdata, pstrb);
        end else if (wr_zero) begin
            wr_half = merge16(en_zero_q, pwdata, pstrb);
        end else if (wr_one) begin
            wr_half = merge16(en_one_q, pwdata, pstrb);
        end else if (wr_two) begin
            wr_half = merge16(en_two_q, pwdata, pstrb);
        end
    end

    ifeb_flag_reg #(
        .WIDTH(16),
        .IMPL_MASK(ifeb_pkg::flag_status_four_mask),
        .RESET_VAL(ifeb_pkg::flag_reset)
    ) u_flag_four (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(wr_four),
        .wr_data(wr_half),
        .set_pulse(flag_set_four),
        .q(flag_four_q)
    );

    ifeb_flag_reg #(
        .WIDTH(16),
        .IMPL_MASK(ifeb_pkg::source_enable_zero_mask),
        .RESET_VAL(ifeb_pkg::enable_reset)
    ) u_en_zero (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(wr_zero),
        .wr_data(wr_half),
        .set_pulse(16'h0000),
        .q(en_zero_q)
    );

    ifeb_flag_reg #(
        .WIDTH(16),
        .IMPL_MASK(ifeb_pkg::source_enable_one_mask),
        .RESET_VAL(ifeb_pkg::enable_reset)
    ) u_en_one (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(wr_one),
        .wr_data(wr_half),
        .set_pulse(16'h0000),
        .q(en_one_q)
    );

    ifeb_flag_reg #(
        .WIDTH(16),
        .IMPL_MASK(ifeb_pkg::source_enable_two_mask),
        .RESET_VAL(ifeb_pkg::enable_reset)
    ) u_en_two (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(wr_two),
        .wr_data(wr_half),
        .set_pulse(16'h0000),
        .q(en_two_q)
    );

    assign prio_wr = merge16({4'h0, prio_r}, pwdata, pstrb);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_r <= ifeb_pkg::group_priority_reset;
        end else if (wr_fire && hit(paddr, ifeb_pkg::group_priority_off)) begin
            prio_r <= prio_wr[11:0] & ifeb_pkg::group_priority_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_enable_r <= ifeb_pkg::event_reset;
        end else if (wr_fire && hit(paddr, ifeb_pkg::event_enable_off) && pstrb[0]) begin
            ev_enable_r <= pwdata[3:0];
        end
    end

    // Forwarded requests: a source passes only with flag, enable and a live priority.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_four_r <= 16'h0000;
            req_zero_r <= 16'h0000;
            req_one_r <= 16'h0000;
            req_two_r <= 16'h0000;
        end else begin
            req_four_r <= gate(flag_four_q, enable_in_four,
                               grp_prio(prio_r, ifeb_pkg::grp_four));
            req_zero_r <= gate(flag_in_zero, en_zero_q,
                               grp_prio(prio_r, ifeb_pkg::grp_zero));
            req_one_r <= gate(flag_in_one, en_one_q,
                              grp_prio(prio_r, ifeb_pkg::grp_one));
            req_two_r <= gate(flag_in_two, en_two_q,
                              grp_prio(prio_r, ifeb_pkg::grp_two));
        end
    end

    // A group event is the first cycle any of its requests is forwarded.
    always_comb begin
        grp_any_nxt[ifeb_pkg::grp_four] = |req_four_r;
        grp_any_nxt[ifeb_pkg::grp_zero] = |req_zero_r;
        grp_any_nxt[ifeb_pkg::grp_one] = |req_one_r;
        grp_any_nxt[ifeb_pkg::grp_two] = |req_two_r;
        ev_set = grp_any_nxt & ~grp_any_r;
        ev_clear = 4'h0;
        if (wr_fire && hit(paddr, ifeb_pkg::event_clear_off) && pstrb[0]) begin
            ev_clear = pwdata[3:0];
        end
        ev_status_nxt = (ev_status_r & ~ev_clear) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_any_r <= 4'h0;
            ev_status_r <= ifeb_pkg::event_reset;
            irq_r <= 1'b0;
        end else begin
            grp_any_r <= grp_any_nxt;
            ev_status_r <= ev_status_nxt;
            irq_r <= |(ev_status_nxt & ev_enable_r);
        end
    end

    ifeb_prio_sel #(
        .N(ifeb_pkg::num_groups)
    ) u_prio (
        .pending(grp_any_nxt),
        .levels(prio_r),
        .level(level_nxt)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_level_r <= ifeb_pkg::prio_disabled;
        end else begin
            irq_level_r <= level_nxt;
        end
    end

    assign flag_out_four = flag_four_q;
    assign req_four = req_four_r;
    assign req_zero = req_zero_r;
    assign req_one = req_one_r;
    assign req_two = req_two_r;
    assign irq_level = irq_level_r;
    assign irq = irq_r;

endmodule // ifeb_top

// [tb/ifeb_top_checker.sv]
`timescale 1ns/10ps
module ifeb_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] flag_set_four,
    input wire logic [15:0] enable_in_four,
    input wire logic [15:0] flag_in_zero,
    input wire logic [15:0] flag_out_four,
    input wire logic [15:0] req_four,
    input wire logic [15:0] req_zero,
    input wire logic [15:0] req_one,
    input wire logic [15:0] req_two,
    input wire logic [2:0] irq_level
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    unmapped_err_a: assert property (psel && !penable && paddr[11:5] != 7'h00 |=> pslverr)
        else $error("no error on unmapped address");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside access cycle");
    flag_set_a: assert property (|(flag_set_four & 16'h00f6) |=>
        (flag_out_four & $past(flag_set_four) & 16'h00f6) == ($past(flag_set_four) & 16'h00f6))
        else $error("request pulse did not set its flag");
    flag_unused_a: assert property ((flag_out_four & 16'hff09) == 16'h0000)
        else $error("unimplemented flag bit set");
    req_four_gate_a: assert property
        ((req_four & ~($past(flag_out_four) & $past(enable_in_four))) == 16'h0000)
        else $error("fourth group request without flag and enable");
    req_zero_gate_a: assert property
        ((req_zero & ~($past(flag_in_zero) & 16'h7fff)) == 16'h0000)
        else $error("group zero request without flag or on unused bit");
    level_cause_a: assert property
        (irq_level != 3'h0 |-> $past(|(req_four | req_zero | req_one | req_two)))
        else $error("priority level without any forwarded request");
endmodule // ifeb_top_checker

// [tb/ifeb_periph_model.sv]
`timescale 1ns/10ps
module ifeb_periph_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] fire,
    input wire logic [15:0] en_hold,
    input wire logic [15:0] lvl_hold,
    output logic [15:0] flag_set_four,
    output logic [15:0] enable_in_four,
    output logic [15:0] flag_in_zero,
    output logic [15:0] flag_in_one,
    output logic [15:0] flag_in_two
);
    // A fired source pulses for one cycle only, so a flag that stays set proves it is sticky.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_set_four <= 16'h0000;
        end else begin
            flag_set_four <= fire;
        end
    end
    assign enable_in_four = en_hold;
    assign flag_in_zero = lvl_hold;
    assign flag_in_one = lvl_hold;
    assign flag_in_two = lvl_hold;
endmodule // ifeb_periph_model

// [tb/interrupt_flag_enable_bank_bench.sv]
`timescale 1ns/10ps
module interrupt_flag_enable_bank_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [2:0] irq_level;
    logic [15:0] flag_set_four, enable_in_four, flag_in_zero, flag_in_one, flag_in_two;
    logic [15:0] flag_out_four, req_four, req_zero, req_one, req_two, fire, en_hold, lvl_hold;
    int n_mismatch, checks;
    // Address, write value, expected readback.
    localparam logic [43:0] rows [0:7] = '{
        44'h000_ffff_00f6,
        44'h004_ffff_7fff,
        44'h008_ffff_fffb,
        44'h00c_ffff_dfff,
        44'h010_ffff_0fff,
        44'h018_ffff_0000,
        44'h014_ffff_0000,
        44'h004_0000_0000};

    ifeb_top ifeb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flag_set_four(flag_set_four),
        .enable_in_four(enable_in_four), .flag_in_zero(flag_in_zero),
        .flag_in_one(flag_in_one), .flag_in_two(flag_in_two), .flag_out_four(flag_out_four),
        .req_four(req_four), .req_zero(req_zero), .req_one(req_one), .req_two(req_two),
        .irq_level(irq_level), .irq(irq));
    ifeb_periph_model ifeb_periph_model_i (.pclk(pclk), .presetn(presetn), .fire(fire),
        .en_hold(en_hold), .lvl_hold(lvl_hold), .flag_set_four(flag_set_four),
        .enable_in_four(enable_in_four), .flag_in_zero(flag_in_zero),
        .flag_in_one(flag_in_one), .flag_in_two(flag_in_two));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task print_verdict;
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One idle cycle follows each transfer, so psel is never driven twice in one step.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                n_mismatch++;
                print_verdict();
            end
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task idle2;
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        fire = 16'h0;
        en_hold = 16'h0;
        lvl_hold = 16'h0;
        presetn = 1'b0;
        n_mismatch = 0;
        checks = 0;
        repeat (5) @(posedge pclk);
        chk("outputs in reset", 32'h0, {11'h0, irq, irq_level, pready, flag_out_four});
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i <= 20; i += 4) begin
            apb(1'b0, i[11:0], 32'h0);
            chk("reset value", (i == 16) ? 32'h924 : 32'h0, rd);
        end
        foreach (rows[k]) begin
            apb(1'b1, rows[k][43:32], {16'h0, rows[k][31:16]});
            apb(1'b0, rows[k][43:32], 32'h0);
            chk("readback", {16'h0, rows[k][15:0]}, rd);
            chk("readback error", 32'h0, {31'h0, er});
        end
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        // The pulse lands on the very edge that writes zero; bit 0 is unused and must stay clear.
        fork
            apb(1'b1, 12'h000, 32'h0);
            begin
                fire <= 16'h0081;
                @(posedge pclk);
                fire <= 16'h0000;
            end
        join
        apb(1'b0, 12'h000, 32'h0);
        chk("flag after race", 32'h0080, rd);
        apb(1'b1, 12'h018, 32'hf);
        apb(1'b1, 12'h01c, 32'h1);
        en_hold <= 16'h0080;
        repeat (3) @(posedge pclk);
        chk("req_four", 32'h0080, {16'h0, req_four});
        chk("irq and level", 32'hf, {28'h0, irq, irq_level});
        apb(1'b0, 12'h014, 32'h0);
        chk("event status", 32'h1, rd & 32'h1);
        lvl_hold <= 16'hffff;
        apb(1'b1, 12'h004, 32'h0010);
        chk("req_one req_two", 32'hfffb_dfff, {req_one, req_two});
        apb(1'b1, 12'h010, 32'h03b);
        idle2();
        chk("req_zero", 32'h0010, {16'h0, req_zero});
        chk("level seven", 32'h7, {29'h0, irq_level});
        chk("groups one two blocked", 32'h0, {req_one, req_two});
        apb(1'b1, 12'h010, 32'h003);
        idle2();
        chk("priority zero blocks", 32'h3, {13'h0, req_zero, irq_level});
        apb(1'b1, 12'h01c, 32'h0);
        idle2();
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, 12'h01c, 32'h1);
        idle2();
        chk("irq unmasked", 32'h1, {31'h0, irq});
        apb(1'b1, 12'h018, 32'h1);
        idle2();
        chk("irq cleared", 32'h0, {31'h0, irq});
        en_hold <= 16'h0000;
        idle2();
        chk("req_four blocked", 32'h0, {16'h0, req_four});
        presetn <= 1'b0;
        @(posedge pclk);
        chk("mid-run reset", 32'h0, {flag_out_four, req_zero});
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h010, 32'h0);
        chk("priority after reset", 32'h924, rd);
        print_verdict();
    end
endmodule // interrupt_flag_enable_bank_bench

bind ifeb_top ifeb_top_checker ifeb_top_checker_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flag_set_four(flag_set_four), .enable_in_four(enable_in_four),
    .flag_in_zero(flag_in_zero), .flag_out_four(flag_out_four), .req_four(req_four),
    .req_zero(req_zero), .req_one(req_one), .req_two(req_two), .irq_level(irq_level));
